// [hdl/pps_data_ram.sv]
/*
 Data RAM of two files of sixteen nibbles, one write port, one read port.
 Assumes the address is already formed from file bit and nibble index.
*/
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_data_ram (
    // Clock
    input wire logic clock,
    input wire logic clk_en,
    // Access
    input wire logic write_en,
    input wire logic [`PPS_RAM_AW-1:0] addr,
    input wire logic [`PPS_NIB_W-1:0] write_data,
    output logic [`PPS_NIB_W-1:0] read_data
);
    logic [`PPS_NIB_W-1:0] mem_q [`PPS_RAM_NIBBLES];

    always_ff @(posedge clock) begin
        if (clk_en && write_en) begin
            mem_q[addr] <= write_data;
        end
    end

    assign read_data = mem_q[addr];

endmodule // pps_data_ram

// [hdl/pps_defines.svh]
/*
 Constants of the paged program sequencer: widths, sizes, reset values,
 counter limits and register offsets on the plain register port.
 Assumes inclusion by bare name from the design files.
*/
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_PAGE_W 4
`define PPS_CNT_W 6
`define PPS_FETCH_W 10
`define PPS_NIB_W 4
`define PPS_H_W 3
`define PPS_PTR_W 7
`define PPS_RAM_AW 5
`define PPS_ROM_BYTES 1024
`define PPS_PAGES 16
`define PPS_PAGE_BYTES 64
`define PPS_RAM_NIBBLES 32
`define PPS_FILE_NIBBLES 16
`define PPS_STACK_DEPTH 3

`define PPS_PAGE_RST 4'hf
`define PPS_SKIP_RST 1'b1
`define PPS_CMP_RST 1'b1
`define PPS_CNT_LAST 6'h3f
`define PPS_CNT_FIRST 6'h00
`define PPS_H_FILE_BIT 2
`define PPS_H_FILE0 3'h0
`define PPS_NIB_LAST 4'hf
`define PPS_NIB_ZERO 4'h0
`define PPS_DEPTH_FULL 2'h3
`define PPS_DEPTH_EMPTY 2'h0

`define PPS_OFS_STATUS 8'h00
`define PPS_OFS_FETCH 8'h04
`define PPS_OFS_ACCUM 8'h08
`define PPS_OFS_POINTER 8'h0c
`define PPS_OFS_INPUT 8'h10
`define PPS_OFS_RAMDATA 8'h14

`endif

// [hdl/pps_pkg.sv]
/*
 Types of the paged program sequencer: the decoded instruction set.
 Assumes the instruction decoder outside hands over one of these per cycle.
*/
package pps_pkg;

    typedef enum logic [4:0] {
        OP_NOP,
        OP_PAGE,
        OP_JUMP,
        OP_CALL,
        OP_RET,
        OP_MOV_H,
        OP_NOT_H,
        OP_MOV_L,
        OP_MOV_A_IMM,
        OP_MOV_A_MEM,
        OP_ADD_SKIP_IMM,
        OP_ADD_SKIP_MEM,
        OP_INC_SKIP_MEM,
        OP_INC_SKIP_A,
        OP_INC_SKIP_L,
        OP_SUB_SKIP_MEM,
        OP_DEC_SKIP_MEM,
        OP_DEC_SKIP_A,
        OP_DEC_SKIP_L,
        OP_CMP_UNEQ_MEM_A,
        OP_CMP_NZ_MEM,
        OP_CMP_UNEQ_L_IMM,
        OP_CMP_UNEQ_L_A,
        OP_CMP_GT_A_MEM,
        OP_CMP_NZ_INPUT,
        OP_BIT_TEST,
        OP_STORE_INC,
        OP_STORE_DEC
    } pps_op_t;

endpackage

// [hdl/pps_return_stack.sv]
/*
 Three-entry return stack as a shift register, entry 0 on top.
 Assumes push and pop are never requested in the same cycle.
*/
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_return_stack (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Stack requests
    input wire logic push,
    input wire logic pop,
    input wire logic [`PPS_FETCH_W-1:0] push_data,
    // Stack state
    output logic [`PPS_FETCH_W-1:0] top,
    output logic [1:0] depth
);
    logic [`PPS_FETCH_W-1:0] entry_q [`PPS_STACK_DEPTH];
    logic [1:0] depth_q;

    // Oldest entry drops out of the bottom when full
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (push) begin
                entry_q[0] <= push_data;
                for (int i = 1; i < `PPS_STACK_DEPTH; i++) begin
                    entry_q[i] <= entry_q[i-1];
                end
            end else if (pop) begin
                for (int i = 0; i < `PPS_STACK_DEPTH - 1; i++) begin
                    entry_q[i] <= entry_q[i+1];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            depth_q <= `PPS_DEPTH_EMPTY;
        end else if (clk_en) begin
            if (push && depth_q != `PPS_DEPTH_FULL) begin
                depth_q <= depth_q + 2'h1;
            end else if (pop && depth_q != `PPS_DEPTH_EMPTY) begin
                depth_q <= depth_q - 2'h1;
            end
        end
    end

    assign top = entry_q[0];
    assign depth = depth_q;

endmodule // pps_return_stack

// [hdl/pps_sequencer.sv]
/*
 Paged program sequencer: page and in-page addressing, conditional jumps
 and calls, return stack, skip flag, compare latch, accumulator and data
 RAM addressing, with a plain register port for observation and control.
 Assumes one decoded instruction per instr_valid cycle, signals synchronous
 to clock, and a master that never raises both strobes at once.
*/
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pps_defines.svh"

module pps_sequencer (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic clk_en,
    // Decoded instruction
    input wire logic instr_valid,
    input wire pps_pkg::pps_op_t instr_op,
    input wire logic [`PPS_CNT_W-1:0] instr_operand,
    // Register port
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    // Sequencer state
    output logic [`PPS_FETCH_W-1:0] fetch_addr,
    output logic skip_flag,
    output logic compare_latch
);
    import pps_pkg::*;

    logic [`PPS_PAGE_W-1:0] page_select_reg_q;
    logic [`PPS_PAGE_W-1:0] page_staging_buf_q;
    logic [`PPS_CNT_W-1:0] in_page_counter_q;
    logic skip_flag_q;
    logic compare_latch_q;
    logic [`PPS_NIB_W-1:0] accum_q;
    logic [`PPS_H_W-1:0] file_sel_q;
    logic [`PPS_NIB_W-1:0] nibble_idx_q;
    logic [`PPS_NIB_W-1:0] input_nibble_q;
    logic clear_pending_q;
    logic [31:0] bus_rdata_q;

    logic step;
    logic branch_taken;
    logic call_push;
    logic ret_pop;
    logic [`PPS_FETCH_W-1:0] stack_top;
    logic [1:0] stack_depth;
    logic [`PPS_NIB_W-1:0] ram_rdata;
    logic [`PPS_RAM_AW-1:0] ram_addr;
    logic [`PPS_CNT_W-1:0] counter_inc;

    logic acc_we;
    logic [`PPS_NIB_W-1:0] acc_d;
    logic idx_we;
    logic [`PPS_NIB_W-1:0] idx_d;
    logic file_we;
    logic [`PPS_H_W-1:0] file_d;
    logic ram_we;
    logic skip_d;
    logic [4:0] alu_wide;

    assign step = clk_en && instr_valid;
    assign counter_inc = in_page_counter_q + 6'h01;
    assign branch_taken = step && skip_flag_q && (instr_op == OP_JUMP || instr_op == OP_CALL);
    assign call_push = branch_taken && instr_op == OP_CALL && !clear_pending_q;
    assign ret_pop = step && instr_op == OP_RET && !clear_pending_q;
    assign ram_addr = {file_sel_q[`PPS_H_FILE_BIT], nibble_idx_q};

    // Fetch address over 16 pages of 64 bytes
    assign fetch_addr = {page_select_reg_q, in_page_counter_q};
    assign skip_flag = skip_flag_q;
    assign compare_latch = compare_latch_q;
    assign bus_rdata = bus_rdata_q;

    pps_return_stack u_return_stack (
        .clock(clock),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .push(call_push),
        .pop(ret_pop),
        .push_data({page_select_reg_q, counter_inc}),
        .top(stack_top),
        .depth(stack_depth)
    );

    pps_data_ram u_data_ram (
        .clock(clock),
        .clk_en(clk_en),
        .write_en(ram_we),
        .addr(ram_addr),
        .write_data(accum_q),
        .read_data(ram_rdata)
    );

    // Page select register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            page_select_reg_q <= `PPS_PAGE_RST;
        end else if (step && !clear_pending_q) begin
            if (branch_taken) begin
                page_select_reg_q <= page_staging_buf_q;
            end else if (ret_pop) begin
                page_select_reg_q <= stack_top[`PPS_FETCH_W-1:`PPS_CNT_W];
            end
        end
    end

    // In-page counter keeps its value through reset
    always_ff @(posedge clock) begin
        if (rst_n && step) begin
            if (clear_pending_q) begin
                in_page_counter_q <= `PPS_CNT_FIRST;
            end else if (branch_taken) begin
                in_page_counter_q <= instr_operand;
            end else if (ret_pop) begin
                in_page_counter_q <= stack_top[`PPS_CNT_W-1:0];
            end else begin
                in_page_counter_q <= counter_inc;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clear_pending_q <= 1'b1;
        end else if (step) begin
            clear_pending_q <= 1'b0;
        end
    end

    // Staging buffer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            page_staging_buf_q <= `PPS_PAGE_RST;
        end else if (step && instr_op == OP_PAGE) begin
            page_staging_buf_q <= instr_operand[`PPS_PAGE_W-1:0];
        end
    end

    // Datapath and skip flag decision
    always_comb begin
        acc_we = 1'b0;
        acc_d = accum_q;
        idx_we = 1'b0;
        idx_d = nibble_idx_q;
        file_we = 1'b0;
        file_d = file_sel_q;
        ram_we = 1'b0;
        skip_d = 1'b1;
        alu_wide = 5'h00;
        case (instr_op)
            OP_JUMP, OP_CALL: begin
                skip_d = 1'b1;
            end
            OP_MOV_H: begin
                file_we = 1'b1;
                file_d = {instr_operand[`PPS_H_FILE_BIT], 2'b00};
            end
            OP_NOT_H: begin
                file_we = 1'b1;
                file_d = {~file_sel_q[`PPS_H_FILE_BIT], file_sel_q[1:0]};
            end
            OP_MOV_L: begin
                idx_we = 1'b1;
                idx_d = instr_operand[`PPS_NIB_W-1:0];
            end
            OP_MOV_A_IMM: begin
                acc_we = 1'b1;
                acc_d = instr_operand[`PPS_NIB_W-1:0];
            end
            OP_MOV_A_MEM: begin
                acc_we = 1'b1;
                acc_d = ram_rdata;
            end
            OP_ADD_SKIP_IMM: begin
                alu_wide = {1'b0, accum_q} + {1'b0, instr_operand[`PPS_NIB_W-1:0]};
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = alu_wide[4];
            end
            OP_ADD_SKIP_MEM: begin
                alu_wide = {1'b0, accum_q} + {1'b0, ram_rdata};
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = alu_wide[4];
            end
            OP_INC_SKIP_MEM: begin
                alu_wide = {1'b0, ram_rdata} + 5'h01;
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = alu_wide[4];
            end
            OP_INC_SKIP_A: begin
                alu_wide = {1'b0, accum_q} + 5'h01;
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = alu_wide[4];
            end
            OP_INC_SKIP_L: begin
                alu_wide = {1'b0, nibble_idx_q} + 5'h01;
                idx_we = 1'b1;
                idx_d = alu_wide[3:0];
                skip_d = alu_wide[4];
            end
            OP_SUB_SKIP_MEM: begin
                alu_wide = {1'b0, ram_rdata} - {1'b0, accum_q};
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = ~alu_wide[4];
            end
            OP_DEC_SKIP_MEM: begin
                alu_wide = {1'b0, ram_rdata} - 5'h01;
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = ~alu_wide[4];
            end
            OP_DEC_SKIP_A: begin
                alu_wide = {1'b0, accum_q} - 5'h01;
                acc_we = 1'b1;
                acc_d = alu_wide[3:0];
                skip_d = ~alu_wide[4];
            end
            OP_DEC_SKIP_L: begin
                alu_wide = {1'b0, nibble_idx_q} - 5'h01;
                idx_we = 1'b1;
                idx_d = alu_wide[3:0];
                skip_d = ~alu_wide[4];
            end
            OP_CMP_UNEQ_MEM_A: skip_d = (ram_rdata != accum_q);
            OP_CMP_NZ_MEM: skip_d = (ram_rdata != `PPS_NIB_ZERO);
            OP_CMP_UNEQ_L_IMM: skip_d = (nibble_idx_q != instr_operand[`PPS_NIB_W-1:0]);
            OP_CMP_UNEQ_L_A: skip_d = (nibble_idx_q != accum_q);
            OP_CMP_GT_A_MEM: skip_d = !(accum_q > ram_rdata);
            OP_CMP_NZ_INPUT: skip_d = (input_nibble_q != `PPS_NIB_ZERO);
            OP_BIT_TEST: skip_d = ram_rdata[instr_operand[1:0]];
            OP_STORE_INC: begin
                ram_we = 1'b1;
                idx_we = 1'b1;
                idx_d = nibble_idx_q + 4'h1;
                skip_d = (nibble_idx_q == `PPS_NIB_LAST);
            end
            OP_STORE_DEC: begin
                ram_we = 1'b1;
                idx_we = 1'b1;
                idx_d = nibble_idx_q - 4'h1;
                skip_d = (nibble_idx_q != `PPS_NIB_ZERO);
            end
            default: begin
                skip_d = 1'b1;
            end
        endcase
        ram_we = ram_we && step;
    end

    // Skip flag
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            skip_flag_q <= `PPS_SKIP_RST;
        end else if (step) begin
            skip_flag_q <= skip_d;
        end
    end

    // Compare latch true when index differs from accumulator
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            compare_latch_q <= `PPS_CMP_RST;
        end else if (step && instr_op == OP_CMP_UNEQ_L_A) begin
            compare_latch_q <= (nibble_idx_q != accum_q);
        end
    end

    // Accumulator; an instruction beats a register write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            accum_q <= `PPS_NIB_ZERO;
        end else if (step && acc_we) begin
            accum_q <= acc_d;
        end else if (clk_en && bus_write && bus_addr == `PPS_OFS_ACCUM) begin
            accum_q <= bus_wdata[`PPS_NIB_W-1:0];
        end
    end

    // RAM pointer stays unknown through reset
    always_ff @(posedge clock) begin
        if (step && (file_we || idx_we)) begin
            if (file_we) begin
                file_sel_q <= file_d;
            end
            if (idx_we) begin
                nibble_idx_q <= idx_d;
            end
        end else if (clk_en && bus_write && bus_addr == `PPS_OFS_POINTER) begin
            file_sel_q <= bus_wdata[`PPS_PTR_W-1:`PPS_NIB_W];
            nibble_idx_q <= bus_wdata[`PPS_NIB_W-1:0];
        end
    end

    // Nibble sensed by the input compare
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            input_nibble_q <= `PPS_NIB_ZERO;
        end else if (clk_en && bus_write && bus_addr == `PPS_OFS_INPUT) begin
            input_nibble_q <= bus_wdata[`PPS_NIB_W-1:0];
        end
    end

    // Read data one cycle after the strobe, else zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            bus_rdata_q <= 32'h0000_0000;
            if (bus_read) begin
                case (bus_addr)
                    `PPS_OFS_STATUS: bus_rdata_q <= {26'h0, stack_depth, 2'b00, compare_latch_q, skip_flag_q};
                    `PPS_OFS_FETCH: bus_rdata_q <= {18'h0, page_staging_buf_q, fetch_addr};
                    `PPS_OFS_ACCUM: bus_rdata_q <= {28'h0, accum_q};
                    `PPS_OFS_POINTER: bus_rdata_q <= {25'h0, file_sel_q, nibble_idx_q};
                    `PPS_OFS_INPUT: bus_rdata_q <= {28'h0, input_nibble_q};
                    `PPS_OFS_RAMDATA: bus_rdata_q <= {28'h0, ram_rdata};
                    default: bus_rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Checks
    property p_wrap;
        @(posedge clock) disable iff (!rst_n)
        (step && !clear_pending_q && !branch_taken && instr_op != OP_RET && in_page_counter_q == `PPS_CNT_LAST)
        |=> (in_page_counter_q == `PPS_CNT_FIRST) && $stable(page_select_reg_q);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap in page");

    property p_taken;
        @(posedge clock) disable iff (!rst_n)
        (branch_taken && !clear_pending_q)
        |=> fetch_addr == {$past(page_staging_buf_q), $past(instr_operand)};
    endproperty
    a_taken: assert property (p_taken) else $error("taken branch address wrong");

    property p_not_taken;
        @(posedge clock) disable iff (!rst_n)
        (step && !skip_flag_q && !clear_pending_q && (instr_op == OP_JUMP || instr_op == OP_CALL))
        |=> skip_flag_q && $stable(page_select_reg_q) && in_page_counter_q == $past(counter_inc);
    endproperty
    a_not_taken: assert property (p_not_taken) else $error("skipped branch misbehaved");

    property p_staging;
        @(posedge clock) disable iff (!rst_n)
        !(step && instr_op == OP_PAGE) |=> $stable(page_staging_buf_q);
    endproperty
    a_staging: assert property (p_staging) else $error("staging buffer changed");

    property p_reset_vals;
        @(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> page_select_reg_q == `PPS_PAGE_RST && page_staging_buf_q == `PPS_PAGE_RST
            && skip_flag_q && compare_latch_q && clear_pending_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_reset_defer;
        @(posedge clock) disable iff (!rst_n)
        (step && clear_pending_q) |=> in_page_counter_q == `PPS_CNT_FIRST && page_select_reg_q == `PPS_PAGE_RST;
    endproperty
    a_reset_defer: assert property (p_reset_defer) else $error("deferred clear missed");

    property p_call_push;
        @(posedge clock) disable iff (!rst_n)
        call_push |=> stack_top == $past({page_select_reg_q, counter_inc})
            && stack_depth == ($past(stack_depth) == `PPS_DEPTH_FULL ? `PPS_DEPTH_FULL : $past(stack_depth) + 2'h1);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push wrong");

    property p_return;
        @(posedge clock) disable iff (!rst_n)
        ret_pop |=> fetch_addr == $past(stack_top);
    endproperty
    a_return: assert property (p_return) else $error("return address wrong");

    property p_latch;
        @(posedge clock) disable iff (!rst_n)
        !(step && instr_op == OP_CMP_UNEQ_L_A) |=> $stable(compare_latch_q);
    endproperty
    a_latch: assert property (p_latch) else $error("compare latch changed");

    property p_file;
        @(posedge clock) disable iff (!rst_n)
        (step && instr_op == OP_MOV_H) |=> file_sel_q[1:0] == 2'b00 && file_sel_q[2] == $past(instr_operand[2]);
    endproperty
    a_file: assert property (p_file) else $error("file select load wrong");

    property p_store_inc;
        @(posedge clock) disable iff (!rst_n)
        (step && instr_op == OP_STORE_INC)
        |=> skip_flag_q == ($past(nibble_idx_q) == `PPS_NIB_LAST) && nibble_idx_q == $past(nibble_idx_q) + 4'h1;
    endproperty
    a_store_inc: assert property (p_store_inc) else $error("store increment flag wrong");

    c_taken: cover property (@(posedge clock) disable iff (!rst_n) branch_taken);
    c_skipped: cover property (@(posedge clock) disable iff (!rst_n) step && !skip_flag_q && instr_op == OP_JUMP);
    c_overflow: cover property (@(posedge clock) disable iff (!rst_n) call_push && stack_depth == `PPS_DEPTH_FULL);
    c_defer: cover property (@(posedge clock) disable iff (!rst_n) step && clear_pending_q);

endmodule // pps_sequencer

// [verification/pps_sequencer_tb.sv]
/*
 Self-checking bench for the paged program sequencer top.
 Assumes the design files are compiled first; drives ports directly.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module tb;
    import pps_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic instr_valid = 1'b0;
    pps_op_t instr_op = OP_NOP;
    logic [5:0] instr_operand = 6'h00;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic [31:0] bus_rdata;
    logic [9:0] fetch_addr;
    logic skip_flag;
    logic compare_latch;
    logic [31:0] rd_q;
    int mismatches = 0;
    int cmp_count = 0;

    pps_sequencer dut_u (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_operand(instr_operand), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .fetch_addr(fetch_addr),
        .skip_flag(skip_flag), .compare_latch(compare_latch));

    always #50 clock = ~clock;

    task automatic ex(input pps_op_t op, input logic [5:0] opd);
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_operand <= opd;
        @(posedge clock);
        instr_valid <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        bus_read <= 1'b1;
        bus_addr <= a;
        @(posedge clock);
        bus_read <= 1'b0;
        #1 rd_q = bus_rdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_write <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clock);
        bus_write <= 1'b0;
    endtask

    task automatic t_reset_seq();
        `CHK({skip_flag, compare_latch}, 2'b11)
        ex(OP_NOP, 6'h00);
        `CHK(fetch_addr, 10'h3c0)
        ex(OP_JUMP, 6'h3e);
        ex(OP_NOP, 6'h00);
        `CHK(fetch_addr, 10'h3ff)
        ex(OP_NOP, 6'h00);
        `CHK(fetch_addr, 10'h3c0)
    endtask

    task automatic t_branch();
        ex(OP_PAGE, 6'h05);
        rd(8'h04);
        `CHK(rd_q, 32'h0000_17c1)
        ex(OP_MOV_A_IMM, 6'h00);
        ex(OP_ADD_SKIP_IMM, 6'h01);
        `CHK(skip_flag, 1'b0)
        ex(OP_JUMP, 6'h12);
        `CHK({skip_flag, fetch_addr}, 11'h7c4)
        ex(OP_JUMP, 6'h12);
        `CHK(fetch_addr, 10'h152)
    endtask

    task automatic t_stack();
        logic [9:0] exp_ret [3] = '{10'h142, 10'h171, 10'h161};
        ex(OP_CALL, 6'h20);
        `CHK(fetch_addr, 10'h160)
        ex(OP_CALL, 6'h30);
        ex(OP_CALL, 6'h01);
        ex(OP_CALL, 6'h02);
        rd(8'h00);
        `CHK(rd_q[5:4], 2'h3)
        for (int i = 0; i < 3; i++) begin
            ex(OP_RET, 6'h00);
            `CHK(fetch_addr, exp_ret[i])
        end
    endtask

    task automatic t_data();
        ex(OP_MOV_L, 6'h03);
        ex(OP_MOV_A_IMM, 6'h03);
        ex(OP_CMP_UNEQ_L_A, 6'h00);
        ex(OP_MOV_A_IMM, 6'h04);
        `CHK(compare_latch, 1'b0)
        ex(OP_CMP_UNEQ_L_A, 6'h00);
        `CHK(compare_latch, 1'b1)
        ex(OP_MOV_H, 6'h04);
        rd(8'h0c);
        `CHK(rd_q, 32'h0000_0043)
        ex(OP_NOT_H, 6'h00);
        rd(8'h0c);
        `CHK(rd_q, 32'h0000_0003)
        ex(OP_MOV_A_IMM, 6'h09);
        ex(OP_MOV_L, 6'h0f);
        ex(OP_STORE_INC, 6'h00);
        `CHK(skip_flag, 1'b1)
        ex(OP_STORE_DEC, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_MOV_L, 6'h0f);
        rd(8'h14);
        `CHK(rd_q, 32'h0000_0009)
        wr(8'h08, 32'h0000_000a);
        rd(8'h08);
        `CHK(rd_q, 32'h0000_000a)
        rd(8'h1c);
        `CHK(rd_q, 32'h0000_0000)
    endtask

    task automatic t_alu();
        logic [9:0] f0;
        wr(8'h0c, 32'h0000_0045);
        wr(8'h10, 32'h0000_0003);
        ex(OP_MOV_A_IMM, 6'h0c);
        ex(OP_STORE_INC, 6'h00);
        ex(OP_MOV_L, 6'h05);
        ex(OP_MOV_A_IMM, 6'h00);
        ex(OP_MOV_A_MEM, 6'h00);
        rd(8'h08);
        `CHK(rd_q, 32'h0000_000c)
        ex(OP_ADD_SKIP_MEM, 6'h00);
        `CHK(skip_flag, 1'b1)
        rd(8'h08);
        `CHK(rd_q, 32'h0000_0008)
        ex(OP_INC_SKIP_A, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_DEC_SKIP_A, 6'h00);
        `CHK(skip_flag, 1'b1)
        ex(OP_INC_SKIP_MEM, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_SUB_SKIP_MEM, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_CMP_GT_A_MEM, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_DEC_SKIP_MEM, 6'h00);
        `CHK(skip_flag, 1'b1)
        ex(OP_CMP_UNEQ_L_IMM, 6'h05);
        `CHK(skip_flag, 1'b0)
        ex(OP_CMP_NZ_MEM, 6'h00);
        `CHK(skip_flag, 1'b1)
        ex(OP_CMP_NZ_INPUT, 6'h00);
        `CHK(skip_flag, 1'b1)
        wr(8'h10, 32'h0000_0000);
        ex(OP_CMP_NZ_INPUT, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_BIT_TEST, 6'h02);
        `CHK(skip_flag, 1'b1)
        ex(OP_BIT_TEST, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_INC_SKIP_L, 6'h00);
        `CHK(skip_flag, 1'b0)
        ex(OP_DEC_SKIP_L, 6'h00);
        `CHK(skip_flag, 1'b1)
        rd(8'h0c);
        `CHK(rd_q, 32'h0000_0045)
        ex(OP_MOV_A_MEM, 6'h00);
        ex(OP_CMP_UNEQ_MEM_A, 6'h00);
        `CHK(skip_flag, 1'b0)
        // Frozen clock enable: instruction must leave no trace
        f0 = fetch_addr;
        @(posedge clock);
        clk_en <= 1'b0;
        ex(OP_JUMP, 6'h00);
        `CHK({skip_flag, fetch_addr}, {1'b0, f0})
        @(posedge clock);
        clk_en <= 1'b1;
    endtask

    task automatic t_mid_reset();
        ex(OP_MOV_A_IMM, 6'h05);
        ex(OP_CMP_UNEQ_L_A, 6'h00);
        `CHK(compare_latch, 1'b0)
        ex(OP_NOP, 6'h00);
        ex(OP_CALL, 6'h1a);
        `CHK(fetch_addr, 10'h15a)
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        `CHK(fetch_addr, 10'h3da)
        rd(8'h00);
        `CHK(rd_q, 32'h0000_0003)
        ex(OP_NOP, 6'h00);
        `CHK(fetch_addr, 10'h3c0)
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        t_reset_seq();
        t_branch();
        t_stack();
        t_data();
        t_alu();
        t_mid_reset();
        summarize();
    end

    // Run needs well under 400 cycles
    initial begin
        #100_000;
        mismatches++;
        summarize();
    end
endmodule // tb
